/* logic/qdc_regs_consts.svh */
// Purpose: Offsets, field positions, reset values and address strides of the control register bank
// Assumes: Byte offsets relative to the module base address
// Notes: Definitions only
`ifndef QDC_REGS_CONSTS_SVH
`define QDC_REGS_CONSTS_SVH

`define OFS_EVT_CLEAR 16'h1040
`define OFS_PED_CODE 16'h1060
`define OFS_TEST_RADDR 16'h1064
`define OFS_SOFT_CONV 16'h1068
`define OFS_SLIDE_CONST 16'h106a
`define OFS_RAW_A 16'h1070
`define OFS_RAW_B 16'h1072
`define OFS_THR_FIRST 16'h1080
`define OFS_THR_LAST 16'h10be
`define OFS_ID_FIRST 16'h8000
`define OFS_ID_LAST 16'hfffe
`define OFS_MAKER_HI 16'h8026
`define OFS_MAKER_MID 16'h802a
`define OFS_MAKER_LO 16'h802e
`define OFS_VERSION 16'h8032
`define OFS_BOARD_HI 16'h8036
`define OFS_BOARD_MID 16'h803a
`define OFS_BOARD_LO 16'h803e
`define OFS_REVISION 16'h804e
`define OFS_SERIAL_HI 16'h8f02
`define OFS_SERIAL_LO 16'h8f06

`define PED_RESET_NEW 8'hb4
`define PED_RESET_OLD 8'h00
`define PED_MIN_NEW 8'h3c
`define PED_MIN_OLD 8'h78
`define SLIDE_CONST_RESET 8'h00
`define SLIDE_ON_RESET 1'b1
`define THR_KILL_BIT 8
`define STRIDE_32CH 2
`define STRIDE_16CH 4
`define IDLE_READ 16'h0000

`endif

/* logic/qdc_regs_pkg.sv */
// Purpose: Types shared by the control register bank
// Assumes: Constants live in qdc_regs_consts.svh
// Notes: Types only
package qdc_regs_pkg;

   typedef struct packed
   {
      logic sel;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bus_req_t;

   typedef struct packed
   {
      logic [7:0] maker_hi;
      logic [7:0] maker_mid;
      logic [7:0] maker_lo;
      logic [7:0] version;
      logic [7:0] board_hi;
      logic [7:0] board_mid;
      logic [7:0] board_lo;
      logic [7:0] revision;
      logic [7:0] serial_hi;
      logic [7:0] serial_lo;
   } ident_t;

endpackage : qdc_regs_pkg

/* logic/qdc_control_register_bank.sv */
// Purpose: Bus-mapped control, status, threshold and identification registers of a charge converter
// Assumes: One bus request per selected cycle; read data returned one cycle after the request
// Notes: Threshold memory is cleared only by the hardware reset input
`include "qdc_regs_consts.svh"

// Overview of operation
// - Any write to the counter clear location zeroes the event counter; nothing stored.
// - Eight-bit read/write pedestal code sets the shared pedestal current.
// - Newer front end: pedestal code resets to 180; 255 is largest current.
// - Older front end: pedestal resets to zero; host should program 120 or more.
// - Write-only test read address selects buffer word read during memory test.
// - Any write to the soft conversion location starts one test conversion.
// - Eight-bit sliding-scale constant drives the converter when sliding scale is off.
// - First raw readback returns latest block A converter value; writes ignored.
// - Second raw readback returns latest block B converter value; writes ignored.
// - One threshold entry per channel from 0x1080 to 0x10BE, stride 2 or 4.
// - Kill bit set discards that channel's data; clear stores it.
// - Thresholds cleared only by hardware reset, never by software data resets.
// - Read-only identification area holds maker, version, board, revision, serial bytes.
// - Serial number high byte at 0x8F02, low byte at 0x8F06.
// - Sliding-scale enable defaults to 1; constant applies only when cleared.
module qdc_control_register_bank #(
   parameter int CHANNELS = 32,
   parameter bit NEW_FRONT_END = 1'b1,
   parameter int TEST_ADDR_BITS = 11,
   parameter qdc_regs_pkg::ident_t IDENT = '0 // Arbitrary identity values
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Register bus
   input wire qdc_regs_pkg::bus_req_t i_bus,
   output logic [15:0] o_rdata,
   output logic o_rvalid,
   // Mode and raw converter values
   input wire logic i_sliding_scale_on,
   input wire logic [15:0] i_block_a_raw_value,
   input wire logic [15:0] i_block_b_raw_value,
   // Channel kill query
   input wire logic [4:0] i_kill_channel,
   output logic o_channel_store,
   // Controls to the acquisition logic
   output logic o_event_count_clear,
   output logic o_soft_conversion,
   output logic [7:0] o_pedestal_code,
   output logic [TEST_ADDR_BITS-1:0] o_test_read_address,
   output logic [7:0] o_slide_dac,
   output logic [CHANNELS-1:0] o_kill_mask
);

   localparam int STRIDE = (CHANNELS == 32) ? `STRIDE_32CH : `STRIDE_16CH;
   localparam logic [7:0] PED_RESET = NEW_FRONT_END ? `PED_RESET_NEW : `PED_RESET_OLD;

   // Elaboration checks on the parameters the logic can serve
   if (CHANNELS != 32 && CHANNELS != 16)
   begin : g_bad_channels
      $error("CHANNELS must be 16 or 32");
   end
   if (TEST_ADDR_BITS < 1 || TEST_ADDR_BITS > 16)
   begin : g_bad_test_addr
      $error("TEST_ADDR_BITS out of range");
   end

   // Channel index of a threshold address, or -1 if none
   function automatic int thr_index(input logic [15:0] a);
      logic [15:0] off;
      off = a - `OFS_THR_FIRST;
      if (a < `OFS_THR_FIRST || a > `OFS_THR_LAST)
         return -1;
      if ((off % STRIDE) != 0)
         return -1;
      return int'(off) / STRIDE;
   endfunction : thr_index

   logic wr_hit;
   logic rd_hit;
   logic [7:0] ped_q;
   logic [7:0] slide_q;
   logic [TEST_ADDR_BITS-1:0] raddr_q;
   logic [8:0] thr_q [CHANNELS];
   logic [15:0] rdata_d;
   int widx;
   int ridx;

   assign wr_hit = i_bus.sel && i_bus.wr;
   assign rd_hit = i_bus.sel && !i_bus.wr;
   assign widx = thr_index(i_bus.addr);
   assign ridx = thr_index(i_bus.addr);

   // Strobes
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_event_count_clear <= 1'b0;
         o_soft_conversion <= 1'b0;
      end
      else
      begin
         o_event_count_clear <= wr_hit && i_bus.addr == `OFS_EVT_CLEAR;
         o_soft_conversion <= wr_hit && i_bus.addr == `OFS_SOFT_CONV;
      end
   end

   // Pedestal code
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         ped_q <= PED_RESET;
      else if (wr_hit && i_bus.addr == `OFS_PED_CODE)
         ped_q <= i_bus.wdata[7:0];
   end

   // Memory test read address
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         raddr_q <= '0;
      else if (wr_hit && i_bus.addr == `OFS_TEST_RADDR)
         raddr_q <= i_bus.wdata[TEST_ADDR_BITS-1:0];
   end

   // Sliding-scale constant and converter input
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         slide_q <= `SLIDE_CONST_RESET;
      else if (wr_hit && i_bus.addr == `OFS_SLIDE_CONST)
         slide_q <= i_bus.wdata[7:0];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_slide_dac <= `SLIDE_CONST_RESET;
      else if (!i_sliding_scale_on)
         o_slide_dac <= slide_q;
      else
         o_slide_dac <= `SLIDE_CONST_RESET;
   end

   // Threshold and kill memory, cleared only by hardware reset
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         for (int i = 0; i < CHANNELS; i++)
            thr_q[i] <= '0;
      end
      else if (wr_hit && widx >= 0)
         thr_q[widx] <= i_bus.wdata[8:0];
   end

   // Kill mask and per-channel store decision
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_kill_mask <= '0;
         o_channel_store <= 1'b1;
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
            o_kill_mask[i] <= thr_q[i][`THR_KILL_BIT];
         if (int'(i_kill_channel) < CHANNELS)
            o_channel_store <= !thr_q[i_kill_channel][`THR_KILL_BIT];
         else
            o_channel_store <= 1'b0;
      end
   end

   // Plain control outputs
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_pedestal_code <= PED_RESET;
         o_test_read_address <= '0;
      end
      else
      begin
         o_pedestal_code <= ped_q;
         o_test_read_address <= raddr_q;
      end
   end

   // Read decode; write-only and unmapped locations read as zero
   always_comb
   begin
      rdata_d = `IDLE_READ;
      case (i_bus.addr)
         `OFS_PED_CODE: rdata_d = {8'h00, ped_q};
         `OFS_SLIDE_CONST: rdata_d = {8'h00, slide_q};
         `OFS_RAW_A: rdata_d = i_block_a_raw_value;
         `OFS_RAW_B: rdata_d = i_block_b_raw_value;
         `OFS_MAKER_HI: rdata_d = {8'h00, IDENT.maker_hi};
         `OFS_MAKER_MID: rdata_d = {8'h00, IDENT.maker_mid};
         `OFS_MAKER_LO: rdata_d = {8'h00, IDENT.maker_lo};
         `OFS_VERSION: rdata_d = {8'h00, IDENT.version};
         `OFS_BOARD_HI: rdata_d = {8'h00, IDENT.board_hi};
         `OFS_BOARD_MID: rdata_d = {8'h00, IDENT.board_mid};
         `OFS_BOARD_LO: rdata_d = {8'h00, IDENT.board_lo};
         `OFS_REVISION: rdata_d = {8'h00, IDENT.revision};
         `OFS_SERIAL_HI: rdata_d = {8'h00, IDENT.serial_hi};
         `OFS_SERIAL_LO: rdata_d = {8'h00, IDENT.serial_lo};
         default:
         begin
            if (ridx >= 0)
               rdata_d = {7'h00, thr_q[ridx]};
            else
               rdata_d = `IDLE_READ;
         end
      endcase
   end

   // Read answer register
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_rdata <= `IDLE_READ;
         o_rvalid <= 1'b0;
      end
      else
      begin
         o_rvalid <= rd_hit;
         if (rd_hit)
            o_rdata <= rdata_d;
      end
   end

endmodule : qdc_control_register_bank

/* verif/qdc_bank_monitor.sv */
// Purpose: Port checker for the control register bank
// Assumes: All ports sampled on the rising clock edge
// Notes: Bound to every bank instance
module qdc_bank_monitor (
   // Clock, reset and bus
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire qdc_regs_pkg::bus_req_t i_bus,
   input wire logic [15:0] o_rdata,
   input wire logic o_rvalid,
   // Sideband
   input wire logic i_sliding_scale_on,
   input wire logic [15:0] i_block_a_raw_value,
   input wire logic o_event_count_clear,
   input wire logic [7:0] o_pedestal_code,
   input wire logic [7:0] o_slide_dac
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire rd = i_bus.sel && !i_bus.wr;
   wire wr = i_bus.sel && i_bus.wr;
   a_clear_pulse: assert property (wr && i_bus.addr == 16'h1040 |=> o_event_count_clear)
      else $error("clear strobe missing");
   a_clear_single: assert property (o_event_count_clear |-> $past(wr && i_bus.addr == 16'h1040))
      else $error("clear strobe without write");
   a_read_answer: assert property (rd |=> o_rvalid)
      else $error("read not answered");
   a_wo_read: assert property (rd && i_bus.addr inside {16'h1040, 16'h1064, 16'h1068} |=> o_rdata == 16'h0000)
      else $error("write-only read not zero");
   a_raw_a: assert property (rd && i_bus.addr == 16'h1070 |=> o_rdata == $past(i_block_a_raw_value))
      else $error("raw value a wrong");
   a_slide_off: assert property (i_sliding_scale_on [*2] |=> o_slide_dac == 8'h00)
      else $error("slide output not zero");
   a_ped_hold: assert property (!(wr && i_bus.addr == 16'h1060) [*3] |=> $stable(o_pedestal_code))
      else $error("pedestal moved without write");
   a_rvalid_cause: assert property (o_rvalid |-> $past(rd))
      else $error("spurious read answer");
endmodule : qdc_bank_monitor

bind qdc_control_register_bank qdc_bank_monitor u_qdc_bank_monitor (.i_clk, .i_sys_rst, .i_bus, .o_rdata,
   .o_rvalid, .i_sliding_scale_on, .i_block_a_raw_value, .o_event_count_clear, .o_pedestal_code, .o_slide_dac);

/* verif/bus_master.sv */
// Purpose: Crate bus master model issuing single register requests
// Assumes: Request held until the taking edge, read data one cycle later
// Notes: Released address and data lines show the inverse of the last value
module bus_master (
   input wire logic i_clk,
   input wire logic [15:0] i_rdata,
   output qdc_regs_pkg::bus_req_t o_bus
);
   timeunit 1ns;
   timeprecision 100ps;
   initial o_bus = '0;
   task xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge i_clk);
      o_bus <= {1'b1, w, a, d};
      @(posedge i_clk);
      o_bus <= {1'b0, ~w, ~a, ~d};
      @(posedge i_clk);
      #1 q = i_rdata;
   endtask : xfer
endmodule : bus_master

/* verif/qdc_control_register_bank_bench.sv */
// Purpose: Self-checking bench for the control register bank
// Assumes: 32 channels, newer front end
// Notes: Random data from a fixed seed
module qdc_control_register_bank_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // Arbitrary identity values
   localparam qdc_regs_pkg::ident_t ID = 80'h5aa5_3cc3_6996_1221_7ee7;
   logic i_clk = 0;
   logic i_sys_rst = 1;
   logic i_sliding_scale_on = 1;
   logic [15:0] i_block_a_raw_value = 0;
   logic [15:0] i_block_b_raw_value = 0;
   logic [4:0] i_kill_channel = 0;
   qdc_regs_pkg::bus_req_t i_bus;
   logic [15:0] o_rdata, q, v, pulses = 0;
   logic o_channel_store, o_event_count_clear, o_soft_conversion;
   logic [7:0] o_pedestal_code, o_slide_dac;
   logic [10:0] o_test_read_address;
   logic [8:0] thr [32];
   logic [31:0] kill_mask;
   int errors = 0;
   int comparisons = 0;
   qdc_control_register_bank #(.IDENT(ID)) u_qdc_control_register_bank (.i_clk, .i_sys_rst, .i_bus, .o_rdata,
      .o_rvalid(), .i_sliding_scale_on, .i_block_a_raw_value, .i_block_b_raw_value, .i_kill_channel,
      .o_channel_store, .o_event_count_clear, .o_soft_conversion, .o_pedestal_code, .o_test_read_address,
      .o_slide_dac, .o_kill_mask(kill_mask));
   bus_master u_bus_master (.i_clk, .i_rdata(o_rdata), .o_bus(i_bus));
   initial forever #12.5 i_clk = ~i_clk;
   // Strobe weights 1 and 2 make a stuck or doubled pulse visible
   // Counting waits for reset so the unknown strobes before the first reset edge are not summed
   always @(posedge i_clk)
      if (!i_sys_rst)
         pulses <= pulses + {15'h0, o_event_count_clear} + {14'h0, o_soft_conversion, 1'b0};
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task end_sim;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (20000) @(posedge i_clk);
      errors++;
      end_sim;
   end
   initial
   begin
      void'($urandom(49));
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 0;
      u_bus_master.xfer(1'b0, 16'h1060, 16'h0000, q);
      chk("ped reset", q, 16'h00b4);
      for (int i = 0; i < 3; i++)
      begin
         v = (i == 0) ? 16'h00ff : 16'd60 + 16'($urandom % 196);
         u_bus_master.xfer(1'b1, 16'h1060, v | 16'ha500, q);
         u_bus_master.xfer(1'b0, 16'h1060, 16'h0000, q);
         chk("ped", q, v);
         chk("ped out", {8'h00, o_pedestal_code}, v);
      end
      v = 16'($urandom % 256);
      u_bus_master.xfer(1'b1, 16'h106a, v, q);
      i_sliding_scale_on <= 0;
      u_bus_master.xfer(1'b0, 16'h106a, 16'h0000, q);
      chk("slide", q, v);
      chk("dac", {8'h00, o_slide_dac}, v);
      i_sliding_scale_on <= 1;
      v = 16'($urandom);
      // Only the read address is written, so it never equals a write address
      u_bus_master.xfer(1'b1, 16'h1064, v, q);
      foreach (thr[i])
         if (i < 5)
         begin
            u_bus_master.xfer(1'b0, 16'h1040 + 16'(i * 20), 16'h0000, q);
            chk("wo read", q, 16'h0000);
         end
      chk("taddr", {5'h00, o_test_read_address}, v & 16'h07ff);
      chk("dac on", {8'h00, o_slide_dac}, 16'h0000);
      for (int c = 0; c < 32; c++)
      begin
         thr[c] = 9'($urandom);
         u_bus_master.xfer(1'b1, 16'h1080 + 16'(2 * c), {7'h7f, thr[c]}, q);
      end
      for (int i = 0; i < 3; i++)
      begin
         u_bus_master.xfer(1'b1, 16'h1040, 16'($urandom), q);
         u_bus_master.xfer(1'b1, 16'h1068, 16'($urandom), q);
      end
      chk("pulses", pulses, 16'd9);
      for (int c = 0; c < 32; c++)
      begin
         i_kill_channel <= 5'(c);
         u_bus_master.xfer(1'b0, 16'h1080 + 16'(2 * c), 16'h0000, q);
         chk("thr", q, {7'h00, thr[c]});
         chk("store", {15'h0, o_channel_store}, {15'h0, ~thr[c][8]});
         chk("kill", {15'h0, kill_mask[c]}, {15'h0, thr[c][8]});
      end
      i_block_a_raw_value <= 16'($urandom);
      i_block_b_raw_value <= 16'($urandom);
      u_bus_master.xfer(1'b1, 16'h1072, 16'hffff, q);
      u_bus_master.xfer(1'b0, 16'h1070, 16'h0000, q);
      chk("raw a", q, i_block_a_raw_value);
      u_bus_master.xfer(1'b0, 16'h1072, 16'h0000, q);
      chk("raw b", q, i_block_b_raw_value);
      u_bus_master.xfer(1'b1, 16'h8f02, 16'h0000, q);
      u_bus_master.xfer(1'b0, 16'h8f02, 16'h0000, q);
      chk("serial hi", q, 16'h007e);
      u_bus_master.xfer(1'b0, 16'h8f06, 16'h0000, q);
      chk("serial lo", q, 16'h00e7);
      u_bus_master.xfer(1'b0, 16'h8026, 16'h0000, q);
      chk("maker", q, 16'h005a);
      i_sys_rst <= 1;
      @(posedge i_clk);
      i_sys_rst <= 0;
      u_bus_master.xfer(1'b0, 16'h10be, 16'h0000, q);
      chk("thr reset", q, 16'h0000);
      end_sim;
   end
endmodule : qdc_control_register_bank_bench
